// ===== verilog/ummd_defs.vh
// address map, target codes and field positions for the memory map decoder
`ifndef UMMD_DEFS_VH
`define UMMD_DEFS_VH

`define UMMD_AW 24
`define UMMD_DW 16
// target codes
`define UMMD_T_NONE 4'h0
`define UMMD_T_FLASH 4'h1
`define UMMD_T_PROGRAM_SRAM 4'h2
`define UMMD_T_EMULATED_PROGRAM_SRAM 4'h3
`define UMMD_T_DATA_SRAM 4'h4
`define UMMD_T_DUAL_PORT_RAM 4'h5
`define UMMD_T_SREG 4'h6
`define UMMD_T_EREG 4'h7
`define UMMD_T_XREG 4'h8
`define UMMD_T_EXT 4'h9
`define UMMD_T_LPB 4'ha
`define UMMD_T_FIREG 4'hb
`define UMMD_T_RSVD 4'hc
// region bounds
`define UMMD_FIREG_LO 24'hffff00
`define UMMD_RSV_TOP_LO 24'hf00000
`define UMMD_EMULATED_PROGRAM_SRAM_LO 24'he80000
`define UMMD_EMULATED_PROGRAM_SRAM_HI 24'he8ffff
`define UMMD_PROGRAM_SRAM_LO 24'he00000
`define UMMD_PROGRAM_SRAM_HI 24'he0ffff
`define UMMD_FLASH_LO 24'hc00000
`define UMMD_FLASH_HI 24'hd0ffff
`define UMMD_FRES_LO 24'hc0f000
`define UMMD_FRES_HI 24'hc0ffff
`define UMMD_EXT_HI_LO 24'h400000
`define UMMD_EXT_HI_HI 24'hbfffff
`define UMMD_XIO_LO 24'h210000
`define UMMD_XIO_HI 24'h3fffff
`define UMMD_LPB0_LO 24'h200000
`define UMMD_LPB0_HI 24'h203fff
`define UMMD_LPB1_LO 24'h207000
`define UMMD_LPB1_HI 24'h20afff
`define UMMD_EXT_MID_LO 24'h010000
`define UMMD_EXT_MID_HI 24'h1fffff
`define UMMD_SREG_LO 24'h00fe00
`define UMMD_DUAL_PORT_RAM_LO 24'h00f600
`define UMMD_DPBIT_LO 24'h00fd00
`define UMMD_DUAL_PORT_RAM_HI 24'h00fdff
`define UMMD_EREG_LO 24'h00f000
`define UMMD_EREG_HI 24'h00f1ff
`define UMMD_XREG_LO 24'h00e000
`define UMMD_XREG_HI 24'h00efff
`define UMMD_DATA_SRAM_LO 24'h008000
`define UMMD_DATA_SRAM_HI 24'h00dfff
// segment and page fields
`define UMMD_SEG_MSB 23
`define UMMD_SEG_LSB 16
`define UMMD_PAGE_MSB 15
`define UMMD_PAGE_LSB 14
// flash fields: 128-bit line, 4-Kbyte sector, 128-byte program block
`define UMMD_LINE_LSB 4
`define UMMD_SECT_LSB 12
`define UMMD_BLK_MSB 11
`define UMMD_BLK_LSB 7
`define UMMD_NMOD 5
// password write addresses in the flash interface space
`define UMMD_PW_LO_ADDR 24'hffff00
`define UMMD_PW_HI_ADDR 24'hffff02

`endif

// ===== verilog/ummd_decoder.v
// unified memory map decoder: routes code fetches and data transfers
`timescale 1ns/1ps
`include "ummd_defs.vh"

// Summary of operation
// - all resources share one linear 24-bit address space and decoder
// - address splits into 256 segments of 64 Kbytes, four 16-Kbyte pages
// - byte and word accesses allowed at every address
// - reserved regions become external bus accesses when the bus exists
// - data memories and both register spaces sit in segment 0
// - every code fetch goes through the program fetch manager
// - every data transfer goes through the data transfer manager
// - both managers share a two-way system bus for cross traffic
// - top 256 dual-port RAM bytes and register-bank locations are bit addressable
// - register bank gives 16 word registers or 16 byte halves
// - two 512-byte register spaces, all registers word wide
// - program SRAM section of programmable size is write protected
// - flash is one 64-Kbyte plus four 256-Kbyte modules of 4-Kbyte sectors
// - sectors erase and program separately, programming in 128-byte blocks
// - sectors grouped in clusters per protection bit, still erased singly
// - top sector of first flash segment reserved, never user storage
// - flash read protection, unlocked temporarily by software password sequence
// - each flash module reads 128-bit lines, modules work in parallel
// - error correction applied to every flash read
// - pipeline optimizations disabled inside the external I/O area
module ummd_decoder (
	input wire clk,
	input wire srst,
	input wire ext_bus_pin,
	input wire f_req,
	input wire [23:0] f_addr,
	input wire d_req,
	input wire [23:0] d_addr,
	input wire d_write,
	input wire d_byte,
	input wire d_erase,
	input wire d_bit_op,
	input wire d_use_gpr,
	input wire [3:0] d_gpr_num,
	input wire [23:0] gpr_ctx_base,
	input wire [15:0] d_wdata,
	input wire [15:0] mem_rdata,
	input wire [15:0] program_sram_wp_size,
	input wire [79:0] flash_wp_bits,
	input wire flash_read_prot,
	input wire [31:0] flash_password,
	input wire flash_relock,
	output reg f_valid,
	output reg [3:0] f_target,
	output reg f_via_sysbus,
	output reg f_fault,
	output reg [4:0] f_flash_mod,
	output reg [19:0] f_line_addr,
	output reg d_valid,
	output reg d_stall,
	output reg [3:0] d_target,
	output reg d_via_sysbus,
	output reg d_fault,
	output reg [23:0] d_eff_addr,
	output reg [7:0] d_segment,
	output reg [1:0] d_page,
	output reg [1:0] d_byte_en,
	output reg [7:0] d_reg_word,
	output reg d_bit_ok,
	output reg d_io_nopipe,
	output reg [15:0] d_rdata,
	output reg [4:0] d_flash_mod,
	output reg flash_ecc_en,
	output reg flash_prog,
	output reg flash_erase,
	output reg [5:0] flash_sector,
	output reg [4:0] flash_block,
	output reg [15:0] flash_wdata,
	output reg flash_unlocked
);

	// password sequence states
	localparam PW_IDLE = 3'b001;
	localparam PW_HALF = 3'b010;
	localparam PW_OPEN = 3'b100;

	reg ext_sync1_r;
	reg ext_sync2_r;
	reg [2:0] pw_state_r;
	reg [2:0] pw_state_nxt;
	wire [23:0] d_a;
	wire [3:0] f_reg;
	wire [3:0] d_reg;
	wire [4:0] f_mod;
	wire [4:0] d_mod;
	wire f_flash;
	wire d_flash;
	wire mod_clash;
	wire f_reserved;
	wire d_reserved;
	wire d_sect_rsvd;
	wire f_sect_rsvd;
	wire program_sram_wp_hit;
	wire [5:0] d_sect;
	wire [6:0] wp_index;
	wire cluster_locked;
	wire read_blocked_f;
	wire read_blocked_d;
	wire d_flash_wr;
	wire d_bitable;
	wire [4:0] gpr_off;

	// one region code for the whole linear space
	// single shared map
	function [3:0] region;
		input [23:0] a;
		begin
			if (a >= `UMMD_FIREG_LO)
				region = `UMMD_T_FIREG;
			else if (a >= `UMMD_RSV_TOP_LO)
				region = `UMMD_T_RSVD;
			else if (a >= `UMMD_EMULATED_PROGRAM_SRAM_LO && a <= `UMMD_EMULATED_PROGRAM_SRAM_HI)
				region = `UMMD_T_EMULATED_PROGRAM_SRAM;
			else if (a >= `UMMD_PROGRAM_SRAM_LO && a <= `UMMD_PROGRAM_SRAM_HI)
				region = `UMMD_T_PROGRAM_SRAM;
			else if (a >= `UMMD_FLASH_LO && a <= `UMMD_FLASH_HI)
				region = `UMMD_T_FLASH;
			else if (a >= `UMMD_EXT_HI_LO && a <= `UMMD_EXT_HI_HI)
				region = `UMMD_T_EXT;
			else if (a >= `UMMD_XIO_LO && a <= `UMMD_XIO_HI)
				region = `UMMD_T_EXT;
			else if (a >= `UMMD_LPB0_LO && a <= `UMMD_LPB0_HI)
				region = `UMMD_T_LPB;
			else if (a >= `UMMD_LPB1_LO && a <= `UMMD_LPB1_HI)
				region = `UMMD_T_LPB;
			else if (a >= `UMMD_EXT_MID_LO && a <= `UMMD_EXT_MID_HI)
				region = `UMMD_T_EXT;
			else if (a >= `UMMD_SREG_LO && a <= 24'h00ffff)
				region = `UMMD_T_SREG;
			else if (a >= `UMMD_DUAL_PORT_RAM_LO && a <= `UMMD_DUAL_PORT_RAM_HI)
				region = `UMMD_T_DUAL_PORT_RAM;
			else if (a >= `UMMD_EREG_LO && a <= `UMMD_EREG_HI)
				region = `UMMD_T_EREG;
			else if (a >= `UMMD_XREG_LO && a <= `UMMD_XREG_HI)
				region = `UMMD_T_XREG;
			else if (a >= `UMMD_DATA_SRAM_LO && a <= `UMMD_DATA_SRAM_HI)
				region = `UMMD_T_DATA_SRAM;
			else if (a < `UMMD_DATA_SRAM_LO)
				region = `UMMD_T_EXT;
			else
				region = `UMMD_T_RSVD;
		end
	endfunction

	// one-hot flash module; module 4 is only its lowest 64 Kbytes
	// module split
	function [4:0] flash_mod;
		input [23:0] a;
		begin
			flash_mod = 5'h00;
			if (a >= `UMMD_FLASH_LO && a <= `UMMD_FLASH_HI)
			begin
				case (a[20:18])
					3'h0: flash_mod = 5'h01;
					3'h1: flash_mod = 5'h02;
					3'h2: flash_mod = 5'h04;
					3'h3: flash_mod = 5'h08;
					default: flash_mod = 5'h10;
				endcase
			end
		end
	endfunction

	// external bus strap comes from a pin
	always @(posedge clk)
	begin
		if (srst)
		begin
			ext_sync1_r <= 1'b0;
			ext_sync2_r <= 1'b0;
		end
		else
		begin
			ext_sync1_r <= ext_bus_pin;
			ext_sync2_r <= ext_sync1_r;
		end
	end

	// register-bank accesses: word n at base+2n, byte halves at base+n
	// bank addressing
	assign gpr_off = d_byte ? {1'b0, d_gpr_num} : {d_gpr_num, 1'b0};
	assign d_a = d_use_gpr ? (gpr_ctx_base + {19'h00000, gpr_off}) : d_addr;

	assign f_reg = region(f_addr);
	assign d_reg = region(d_a);
	assign f_mod = flash_mod(f_addr);
	assign d_mod = flash_mod(d_a);
	assign f_flash = (f_reg == `UMMD_T_FLASH);
	assign d_flash = (d_reg == `UMMD_T_FLASH);
	assign f_reserved = (f_reg == `UMMD_T_RSVD);
	assign d_reserved = (d_reg == `UMMD_T_RSVD);

	assign f_sect_rsvd = (f_addr >= `UMMD_FRES_LO && f_addr <= `UMMD_FRES_HI);
	assign d_sect_rsvd = (d_a >= `UMMD_FRES_LO && d_a <= `UMMD_FRES_HI);

	// same-module fetch and data collide; different modules run together
	assign mod_clash = f_req && d_req && ((f_mod & d_mod) != 5'h00);

	// sector within module: 64 sectors per 256-Kbyte module, 16 in module 4
	// per-sector index
	assign d_sect = d_a[17:12];
	// four sectors share one protection bit, 16 bits per 256-Kbyte module, 4 in module 4
	assign wp_index = {d_a[20:18], d_sect[5:2]} + {3'h0, 4'h0};
	assign cluster_locked = flash_wp_bits[wp_index] && !pw_state_r[2];
	assign d_flash_wr = d_flash && d_write;

	// protected program SRAM section from its base upward
	assign program_sram_wp_hit = (d_reg == `UMMD_T_PROGRAM_SRAM) && d_write &&
		(d_a[15:0] < program_sram_wp_size);

	// reads blocked while read-protected and not unlocked
	assign read_blocked_f = f_flash && flash_read_prot && !pw_state_r[2];
	assign read_blocked_d = d_flash && !d_write && flash_read_prot && !pw_state_r[2];

	// bit addressable: upper dual-port bytes, register spaces, bank cells
	assign d_bitable = (d_a >= `UMMD_DPBIT_LO && d_a <= `UMMD_DUAL_PORT_RAM_HI) ||
		(d_reg == `UMMD_T_SREG) || (d_reg == `UMMD_T_EREG) ||
		(d_use_gpr && d_reg == `UMMD_T_DUAL_PORT_RAM);

	// password sequence: low half then high half, any other write restarts
	// temporary unlock
	always @*
	begin
		pw_state_nxt = pw_state_r;
		case (pw_state_r)
			PW_IDLE:
			begin
				if (d_req && d_write && !d_byte && d_a == `UMMD_PW_LO_ADDR &&
					d_wdata == flash_password[15:0])
					pw_state_nxt = PW_HALF;
			end
			PW_HALF:
			begin
				if (d_req && d_write)
				begin
					if (!d_byte && d_a == `UMMD_PW_HI_ADDR &&
						d_wdata == flash_password[31:16])
						pw_state_nxt = PW_OPEN;
					else
						pw_state_nxt = PW_IDLE;
				end
			end
			PW_OPEN:
				pw_state_nxt = PW_OPEN;
			default:
				pw_state_nxt = PW_IDLE;
		endcase
		// relock wins, since unlocking is meant to be short-lived
		if (flash_relock)
			pw_state_nxt = PW_IDLE;
	end

	always @(posedge clk)
	begin
		if (srst)
			pw_state_r <= PW_IDLE;
		else
			pw_state_r <= pw_state_nxt;
	end

	// fetch side answer one cycle after the request
	always @(posedge clk)
	begin
		if (srst)
		begin
			f_valid <= 1'b0;
			f_target <= `UMMD_T_NONE;
			f_via_sysbus <= 1'b0;
			f_fault <= 1'b0;
			f_flash_mod <= 5'h00;
			f_line_addr <= 20'h00000;
		end
		else
		begin
			f_valid <= f_req;
			// fetch manager owns flash and program SRAM
			f_target <= !f_req ? `UMMD_T_NONE :
				(f_reserved && ext_sync2_r) ? `UMMD_T_EXT : f_reg;
			// fetches outside program memory cross the system bus, except reserved ones with no external bus
			f_via_sysbus <= f_req && !f_flash && f_reg != `UMMD_T_PROGRAM_SRAM &&
				f_reg != `UMMD_T_EMULATED_PROGRAM_SRAM && !(f_reserved && !ext_sync2_r);
			f_fault <= f_req && (f_sect_rsvd || read_blocked_f);
			f_flash_mod <= f_req ? f_mod : 5'h00;
			// one 128-bit line per flash read
			f_line_addr <= f_addr[23:`UMMD_LINE_LSB];
		end
	end

	// data side answer one cycle after the request
	always @(posedge clk)
	begin
		if (srst)
		begin
			d_valid <= 1'b0;
			d_stall <= 1'b0;
			d_target <= `UMMD_T_NONE;
			d_via_sysbus <= 1'b0;
			d_fault <= 1'b0;
			d_eff_addr <= 24'h000000;
			d_segment <= 8'h00;
			d_page <= 2'h0;
			d_byte_en <= 2'h0;
			d_reg_word <= 8'h00;
			d_bit_ok <= 1'b0;
			d_io_nopipe <= 1'b0;
			d_rdata <= 16'h0000;
			d_flash_mod <= 5'h00;
		end
		else
		begin
			// data loses a same-module clash; fetches keep the pipe fed
			d_stall <= mod_clash;
			d_valid <= d_req && !mod_clash;
			// reserved goes external when the bus exists
			if (d_req && d_reserved && ext_sync2_r)
				d_target <= `UMMD_T_EXT;
			// everything else is steered by the data manager
			else
				d_target <= d_req ? d_reg : `UMMD_T_NONE;
			// program memory and external traffic use the system bus
			d_via_sysbus <= d_req && (d_flash || d_reg == `UMMD_T_PROGRAM_SRAM ||
				d_reg == `UMMD_T_EMULATED_PROGRAM_SRAM || d_reg == `UMMD_T_EXT ||
				d_reg == `UMMD_T_LPB || (d_reserved && ext_sync2_r));
			d_fault <= d_req && (program_sram_wp_hit || d_sect_rsvd || read_blocked_d ||
				(d_flash_wr && cluster_locked) || (d_bit_op && !d_bitable));
			d_eff_addr <= d_a;
			d_segment <= d_a[`UMMD_SEG_MSB:`UMMD_SEG_LSB];
			d_page <= d_a[`UMMD_PAGE_MSB:`UMMD_PAGE_LSB];
			// byte lane from address bit 0, word uses both
			if (!d_req)
				d_byte_en <= 2'h0;
			else if (d_byte)
				d_byte_en <= d_a[0] ? 2'h2 : 2'h1;
			else
				d_byte_en <= 2'h3;
			// register spaces hold 256 word registers each
			d_reg_word <= d_a[8:1];
			d_bit_ok <= d_req && d_bit_op && d_bitable;
			// no pipeline shortcuts in external I/O area
			d_io_nopipe <= d_req && d_a >= `UMMD_XIO_LO && d_a <= `UMMD_XIO_HI;
			// reserved read without external bus returns zero
			if (d_reserved && !ext_sync2_r)
				d_rdata <= 16'h0000;
			else if (read_blocked_d)
				d_rdata <= 16'h0000;
			else
				d_rdata <= mem_rdata;
			d_flash_mod <= d_req ? d_mod : 5'h00;
		end
	end

	// flash program and erase strobes, one cycle after the write
	always @(posedge clk)
	begin
		if (srst)
		begin
			flash_ecc_en <= 1'b0;
			flash_prog <= 1'b0;
			flash_erase <= 1'b0;
			flash_sector <= 6'h00;
			flash_block <= 5'h00;
			flash_wdata <= 16'h0000;
			flash_unlocked <= 1'b0;
		end
		else
		begin
			flash_ecc_en <= (f_req && f_flash) || (d_req && !mod_clash && d_flash &&
				!d_write);
			// 128-byte program block or whole-sector erase
			flash_prog <= d_req && !mod_clash && d_flash_wr && !d_erase &&
				!cluster_locked && !d_sect_rsvd;
			// erase still names a single sector
			flash_erase <= d_req && !mod_clash && d_flash_wr && d_erase &&
				!cluster_locked && !d_sect_rsvd;
			flash_sector <= d_sect;
			flash_block <= d_a[`UMMD_BLK_MSB:`UMMD_BLK_LSB];
			flash_wdata <= d_wdata;
			flash_unlocked <= pw_state_nxt[2];
		end
	end

endmodule // ummd_decoder

// ===== dv/ummd_checker_assertions.sv
// port-level assertions for the memory map decoder
`timescale 1ns/1ps
module ummd_checker (
	input wire clk,
	input wire srst,
	input wire f_req,
	input wire [23:0] f_addr,
	input wire f_valid,
	input wire f_fault,
	input wire [19:0] f_line_addr,
	input wire d_req,
	input wire [23:0] d_addr,
	input wire d_byte,
	input wire d_use_gpr,
	input wire d_valid,
	input wire d_stall,
	input wire [23:0] d_eff_addr,
	input wire [7:0] d_segment,
	input wire [1:0] d_page,
	input wire [1:0] d_byte_en,
	input wire d_io_nopipe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// fetch answered exactly one cycle on, and only then
	chk_fetch_answer: assert property (f_req |=> f_valid)
		else $error("fetch not answered");
	chk_fetch_quiet: assert property (!f_req |=> !f_valid)
		else $error("fetch answer without request");
	// data request ends in either done or retry, never both
	chk_data_answer: assert property (d_req |=> (d_valid != d_stall))
		else $error("data answer missing or doubled");
	chk_seg_split: assert property (d_req && !d_use_gpr |=> !d_valid ||
		(d_segment == $past(d_addr[23:16]) && d_page == $past(d_addr[15:14])))
		else $error("segment or page field wrong");
	chk_eff_addr: assert property (d_req && !d_use_gpr |=> !d_valid || d_eff_addr == $past(d_addr))
		else $error("effective address differs");
	chk_word_lanes: assert property (d_req && !d_byte |=> !d_valid || d_byte_en == 2'b11)
		else $error("word lanes wrong");
	chk_byte_lane: assert property (d_req && d_byte && !d_use_gpr |=>
		!d_valid || d_byte_en == ($past(d_addr[0]) ? 2'b10 : 2'b01))
		else $error("byte lane wrong");
	chk_rsvd_sector: assert property (f_req && f_addr[23:12] == 12'hc0f |=> f_fault)
		else $error("reserved sector fetch not faulted");
	chk_line_addr: assert property (f_req |=> f_line_addr == $past(f_addr[23:4]))
		else $error("line address wrong");
	chk_io_nopipe: assert property (d_req && !d_use_gpr && d_addr >= 24'h210000
		&& d_addr <= 24'h3fffff |=> d_io_nopipe)
		else $error("io access kept pipelining");
	cover property (d_stall);
	cover property (f_valid && f_fault);
	cover property (d_io_nopipe);
endmodule // ummd_checker

// ===== dv/ummd_mem_model.sv
// far-side memory answering reads with an address-derived word
`timescale 1ns/1ps
module ummd_mem_model (
	input wire clk,
	input wire d_req,
	input wire [23:0] d_addr,
	output reg [15:0] mem_rdata
);
	reg [15:0] idle_r = 16'h0000;
	// idle pattern moves each cycle so stale data never looks valid
	always @(posedge clk)
		idle_r <= idle_r + 16'h3b1d;
	always @*
		mem_rdata = d_req ? {d_addr[7:0], ~d_addr[15:8]} : idle_r;
endmodule // ummd_mem_model

// ===== dv/tb_top.sv
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
`define check_eq(nm, e, g) begin n_tests++; if ((g) !== (e)) begin $display("wrong value %s exp %h got %h", nm, e, g); fails++; end end
module tb_top;
	reg clk = 1'b0;
	reg srst = 1'b1;
	reg ext_bus_pin = 1'b1;
	reg f_req = 1'b0;
	reg [23:0] f_addr = 24'h000000;
	reg d_req = 1'b0;
	reg [23:0] d_addr = 24'h000000;
	reg d_write = 1'b0;
	reg d_byte = 1'b0;
	reg d_erase = 1'b0;
	reg d_bit_op = 1'b0;
	reg d_use_gpr = 1'b0;
	reg [3:0] d_gpr_num = 4'h0;
	reg [23:0] gpr_ctx_base = 24'h00f600;
	reg [15:0] d_wdata = 16'h0000;
	reg [15:0] program_sram_wp_size = 16'h0000;
	reg [79:0] flash_wp_bits = 80'h0;
	reg flash_read_prot = 1'b0;
	reg [31:0] flash_password = 32'h5a3c1234;
	reg flash_relock = 1'b0;
	wire [15:0] mem_rdata;
	wire f_valid, f_via_sysbus, f_fault, d_valid, d_stall, d_via_sysbus, d_fault;
	wire d_bit_ok, d_io_nopipe, flash_prog, flash_erase, flash_unlocked, flash_ecc_en;
	wire [3:0] f_target, d_target;
	wire [4:0] f_flash_mod, flash_block, d_flash_mod;
	wire [19:0] f_line_addr;
	wire [23:0] d_eff_addr;
	wire [7:0] d_segment, d_reg_word;
	wire [1:0] d_page, d_byte_en;
	wire [15:0] d_rdata, flash_wdata;
	wire [5:0] flash_sector;
	integer fails = 0;
	integer n_tests = 0;
	integer cycles = 0;
	integer i;
	reg [27:0] ent;
	// address and expected target, at least one entry per target code other than none and reserved
	function [27:0] map_ent(input integer k);
	begin
		case (k)
			0: map_ent = 28'h0080004;
			1: map_ent = 28'h00f6005;
			2: map_ent = 28'h00fe006;
			3: map_ent = 28'h00f0007;
			4: map_ent = 28'h00e0008;
			5: map_ent = 28'h0000009;
			6: map_ent = 28'h200000a;
			7: map_ent = 28'h2100009;
			8: map_ent = 28'hffff00b;
			9: map_ent = 28'hc400001;
			10: map_ent = 28'he000002;
			11: map_ent = 28'he800003;
			default: map_ent = 28'h4000009;
		endcase
	end
	endfunction

	ummd_decoder dut (.clk(clk), .srst(srst), .ext_bus_pin(ext_bus_pin), .f_req(f_req),
		.f_addr(f_addr), .d_req(d_req), .d_addr(d_addr), .d_write(d_write), .d_byte(d_byte),
		.d_erase(d_erase), .d_bit_op(d_bit_op), .d_use_gpr(d_use_gpr), .d_gpr_num(d_gpr_num),
		.gpr_ctx_base(gpr_ctx_base), .d_wdata(d_wdata), .mem_rdata(mem_rdata),
		.program_sram_wp_size(program_sram_wp_size), .flash_wp_bits(flash_wp_bits),
		.flash_read_prot(flash_read_prot), .flash_password(flash_password),
		.flash_relock(flash_relock), .f_valid(f_valid), .f_target(f_target),
		.f_via_sysbus(f_via_sysbus), .f_fault(f_fault), .f_flash_mod(f_flash_mod),
		.f_line_addr(f_line_addr), .d_valid(d_valid), .d_stall(d_stall), .d_target(d_target),
		.d_via_sysbus(d_via_sysbus), .d_fault(d_fault), .d_eff_addr(d_eff_addr),
		.d_segment(d_segment), .d_page(d_page), .d_byte_en(d_byte_en),
		.d_reg_word(d_reg_word), .d_bit_ok(d_bit_ok), .d_io_nopipe(d_io_nopipe),
		.d_rdata(d_rdata), .d_flash_mod(d_flash_mod), .flash_ecc_en(flash_ecc_en),
		.flash_prog(flash_prog), .flash_erase(flash_erase),
		.flash_sector(flash_sector), .flash_block(flash_block), .flash_wdata(flash_wdata),
		.flash_unlocked(flash_unlocked));
	ummd_mem_model u_mem (.clk(clk), .d_req(d_req), .d_addr(d_addr), .mem_rdata(mem_rdata));

	always #5 clk = ~clk;
	// hang guard: far above the roughly 130 cycles the run needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			report_and_stop;
		end
	end

	// one request cycle; flags are write, byte, erase, bit op, register
	task xfer(input fr, input [23:0] fa, input dr, input [23:0] da, input [4:0] fl,
		input [15:0] wd);
	begin
		@(posedge clk);
		{f_req, f_addr, d_req, d_addr, d_wdata} <= {fr, fa, dr, da, wd};
		{d_write, d_byte, d_erase, d_bit_op, d_use_gpr} <= fl;
		@(posedge clk);
		{f_req, d_req} <= 2'b00;
		@(negedge clk);
	end
	endtask

	task dx(input [23:0] a, input [4:0] fl, input [15:0] wd);
		xfer(1'b0, 24'h000000, 1'b1, a, fl, wd);
	endtask

	task t_map;
	begin
		for (i = 0; i < 13; i++)
		begin
			ent = map_ent(i);
			dx(ent[27:4], 5'b00000, 16'h0000);
			`check_eq("target", ent[3:0], d_target)
			`check_eq("segment", ent[27:20], d_segment)
			`check_eq("rdata", {ent[11:4], ~ent[19:12]}, d_rdata)
		end
	end
	endtask

	task t_rsvd;
	begin
		@(posedge clk) ext_bus_pin <= 1'b0;
		repeat (3) @(posedge clk);
		dx(24'hf00000, 5'b00000, 16'h0000);
		`check_eq("rsvd target", 4'hc, d_target)
		`check_eq("rsvd rdata", 16'h0000, d_rdata)
		@(posedge clk) ext_bus_pin <= 1'b1;
		repeat (3) @(posedge clk);
		dx(24'hf00000, 5'b00000, 16'h0000);
		`check_eq("rsvd ext", 4'h9, d_target)
		@(negedge clk);
		`check_eq("idle target", 4'h0, d_target)
	end
	endtask

	task t_lanes;
	begin
		dx(24'h008001, 5'b01000, 16'h0000);
		`check_eq("odd lane", 2'b10, d_byte_en)
		dx(24'h008002, 5'b01000, 16'h0000);
		`check_eq("even lane", 2'b01, d_byte_en)
		// register spaces only read, never written
		dx(24'h00ffe2, 5'b00000, 16'h0000);
		`check_eq("reg word", 8'hf1, d_reg_word)
		dx(24'h00f1fe, 5'b00000, 16'h0000);
		`check_eq("ereg word", 8'hff, d_reg_word)
	end
	endtask

	task t_fetch;
	begin
		xfer(1'b1, 24'hc0f000, 1'b0, 24'h000000, 5'b00000, 16'h0000);
		`check_eq("rsvd fault", 1'b1, f_fault)
		xfer(1'b1, 24'hc40010, 1'b0, 24'h000000, 5'b00000, 16'h0000);
		`check_eq("module", 5'b00010, f_flash_mod)
		`check_eq("line", 20'hc4001, f_line_addr)
		`check_eq("ecc on", 1'b1, flash_ecc_en)
		xfer(1'b1, 24'hf00000, 1'b0, 24'h000000, 5'b00000, 16'h0000);
		`check_eq("rsvd fetch", 4'h9, f_target)
		xfer(1'b1, 24'hd00000, 1'b0, 24'h000000, 5'b00000, 16'h0000);
		`check_eq("small module", 5'b10000, f_flash_mod)
		xfer(1'b1, 24'he00000, 1'b0, 24'h000000, 5'b00000, 16'h0000);
		`check_eq("program_sram fetch", 4'h2, f_target)
		xfer(1'b1, 24'h400000, 1'b0, 24'h000000, 5'b00000, 16'h0000);
		`check_eq("ext fetch bus", 1'b1, f_via_sysbus)
	end
	endtask

	task t_program_sram;
	begin
		@(posedge clk) program_sram_wp_size <= 16'h0100;
		dx(24'he000fe, 5'b10000, 16'h1111);
		`check_eq("wp fault", 1'b1, d_fault)
		`check_eq("program_sram bus", 1'b1, d_via_sysbus)
		dx(24'he00100, 5'b10000, 16'h1111);
		`check_eq("wp free", 1'b0, d_fault)
	end
	endtask

	task t_flash;
	begin
		dx(24'hc41080, 5'b10000, 16'ha5c3);
		`check_eq("prog", 1'b1, flash_prog)
		`check_eq("ecc write", 1'b0, flash_ecc_en)
		`check_eq("sector", 6'h01, flash_sector)
		`check_eq("block", 5'h01, flash_block)
		`check_eq("wdata", 16'ha5c3, flash_wdata)
		dx(24'hc42000, 5'b10100, 16'h0000);
		`check_eq("erase", 1'b1, flash_erase)
		@(posedge clk) flash_wp_bits <= 80'h20000;
		dx(24'hc47000, 5'b10000, 16'h0000);
		`check_eq("cluster locked", 1'b1, d_fault)
		dx(24'hc43000, 5'b10000, 16'h0000);
		`check_eq("next cluster", 1'b1, flash_prog)
		dx(24'hc0f000, 5'b10000, 16'h0000);
		`check_eq("rsvd write", 1'b1, d_fault)
	end
	endtask

	task t_pass;
	begin
		@(posedge clk) flash_read_prot <= 1'b1;
		dx(24'hc40000, 5'b00000, 16'h0000);
		`check_eq("locked read", 16'h0000, d_rdata)
		dx(24'hffff00, 5'b10000, 16'h1234);
		dx(24'hffff02, 5'b10000, 16'h5a3c);
		`check_eq("unlocked", 1'b1, flash_unlocked)
		dx(24'hc40000, 5'b00000, 16'h0000);
		`check_eq("open read", 1'b0, d_fault)
		`check_eq("open rdata", 16'h00ff, d_rdata)
		@(posedge clk) flash_relock <= 1'b1;
		@(posedge clk) flash_relock <= 1'b0;
		@(negedge clk);
		`check_eq("relocked", 1'b0, flash_unlocked)
	end
	endtask

	task t_clash;
	begin
		xfer(1'b1, 24'hc40000, 1'b1, 24'hc40100, 5'b00000, 16'h0000);
		`check_eq("same module", 1'b1, d_stall)
		xfer(1'b1, 24'hc40000, 1'b1, 24'hc80000, 5'b00000, 16'h0000);
		`check_eq("parallel", 1'b1, d_valid)
		`check_eq("data module", 5'h04, d_flash_mod)
	end
	endtask

	// wrong second half restarts; mid-run reset relocks
	task t_reset;
	begin
		dx(24'hffff00, 5'b10000, 16'h1234);
		dx(24'hffff02, 5'b11000, 16'h5a3c);
		`check_eq("byte half", 1'b0, flash_unlocked)
		dx(24'hffff00, 5'b10000, 16'h1234);
		dx(24'hffff02, 5'b10000, 16'h5a3c);
		`check_eq("reopened", 1'b1, flash_unlocked)
		@(posedge clk) srst <= 1'b1;
		@(posedge clk) srst <= 1'b0;
		@(negedge clk);
		`check_eq("reset lock", 1'b0, flash_unlocked)
		`check_eq("reset target", 4'h0, d_target)
		repeat (2) @(posedge clk);
		dx(24'h008000, 5'b00000, 16'h0000);
		`check_eq("after reset", 4'h4, d_target)
	end
	endtask

	task t_bits;
	begin
		dx(24'h00fd00, 5'b00010, 16'h0000);
		`check_eq("top bits", 1'b1, d_bit_ok)
		dx(24'h00f600, 5'b00010, 16'h0000);
		`check_eq("low bits", 1'b1, d_fault)
		@(posedge clk) d_gpr_num <= 4'h3;
		dx(24'h000000, 5'b00011, 16'h0000);
		`check_eq("reg bits", 1'b1, d_bit_ok)
		`check_eq("reg word", 24'h00f606, d_eff_addr)
		dx(24'h000000, 5'b01001, 16'h0000);
		`check_eq("reg byte", 24'h00f603, d_eff_addr)
	end
	endtask

	task report_and_stop;
	begin
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask

	initial
	begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		t_map;
		t_rsvd;
		t_lanes;
		t_fetch;
		t_program_sram;
		t_flash;
		t_pass;
		t_clash;
		t_bits;
		t_reset;
		report_and_stop;
	end
endmodule // tb_top

bind ummd_decoder ummd_checker u_chk (.clk(clk), .srst(srst), .f_req(f_req), .f_addr(f_addr),
	.f_valid(f_valid), .f_fault(f_fault), .f_line_addr(f_line_addr), .d_req(d_req),
	.d_addr(d_addr), .d_byte(d_byte), .d_use_gpr(d_use_gpr), .d_valid(d_valid),
	.d_stall(d_stall), .d_eff_addr(d_eff_addr), .d_segment(d_segment), .d_page(d_page),
	.d_byte_en(d_byte_en), .d_io_nopipe(d_io_nopipe));
